// File: cs_pkg.sv
// Package for the sub-to-main clock switch: register map, field positions,
// reset values, counts and the switch state encoding.
// Assumes a single 50 MHz ref_clk domain and a plain strobe register port.
package cs_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets (byte-wide registers on the plain port)
  localparam logic [7:0] OFS_SETTLE_SELECT = 8'h00;
  localparam logic [7:0] OFS_RUN_CONTROL = 8'h01;
  localparam logic [7:0] OFS_SETTLE_STATUS = 8'h02;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h03;

  // Settle select field: bits 2..0, bits 7..3 read zero
  localparam int SEL_MSB = 2;
  localparam int SEL_W = 3;

  // Run control field positions
  localparam int BIT_MAIN_HALT = 7;
  localparam int BIT_SUB_HALT = 6;
  localparam int BIT_MIDDLE_ON = 1;
  localparam int BIT_FAST_HALT = 0;

  // System clock select field positions
  localparam int BIT_CLK_STATUS = 7;
  localparam int BIT_CPU_SRC_SEL = 6;
  localparam int BIT_MAIN_SRC_STS = 5;
  localparam int BIT_MAIN_SRC_SEL = 4;
  localparam int BIT_AUX_SRC_STS = 1;
  localparam int BIT_AUX_SRC_SEL = 0;

  // Values after reset
  localparam logic [2:0] RST_SETTLE_SEL = 3'h7;
  localparam logic RST_MAIN_HALT = 1'b1;
  localparam logic RST_SUB_HALT = 1'b1;
  localparam logic RST_MIDDLE_ON = 1'b0;
  localparam logic RST_FAST_HALT = 1'b0;
  localparam logic RST_CPU_SRC_SEL = 1'b0;
  localparam logic RST_MAIN_SRC_SEL = 1'b0;
  localparam logic RST_AUX_SRC_SEL = 1'b0;

  // Settle counter: counts main oscillator edges, saturates at 2^18
  localparam int SETTLE_CNT_W = 19;
  localparam logic [18:0] SETTLE_CNT_MAX = 19'h40000;

  // Cycles of ref_clk that a source change takes to complete
  localparam logic [3:0] SWITCH_CYCLES = 4'h4;

  // Clock switch states
  typedef enum logic [3:0] {
    CS_ON_MAIN = 4'b0001,
    CS_TO_SUB = 4'b0010,
    CS_ON_SUB = 4'b0100,
    CS_TO_MAIN = 4'b1000
  } cs_switch_state_t;

endpackage : cs_pkg

// File: cs_settle_counter.sv
// Main oscillator settle counter with eight elapsed flags.
// Assumes main_osc_in is the raw oscillator output, slower than ref_clk / 2.
`timescale 1ns/100ps
module cs_settle_counter
  import cs_pkg::*;
(
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic osc_running, // Main oscillator enabled
  input wire logic main_osc_in, // Raw main oscillator output
  output logic [7:0] settled_reg // Elapsed flags, 2^8 in bit 7
);

  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic prev_reg, prev_next;
  logic [SETTLE_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] settled_next;

  // Count rising edges of the synchronised oscillator; halting clears the count and the flags
  always_comb begin
    sync1_next = main_osc_in;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    cnt_next = cnt_reg;
    if (!osc_running) begin
      cnt_next = '0;
    end else if (sync2_reg && !prev_reg && (cnt_reg != SETTLE_CNT_MAX)) begin
      cnt_next = cnt_reg + 19'h00001; // Saturates so flags never wrap back
    end
    // Thresholds rise monotonically, so flags set in increasing count order
    settled_next[7] = cnt_reg >= 19'h00100;
    settled_next[6] = cnt_reg >= 19'h00200;
    settled_next[5] = cnt_reg >= 19'h00400;
    settled_next[4] = cnt_reg >= 19'h00800;
    settled_next[3] = cnt_reg >= 19'h02000;
    settled_next[2] = cnt_reg >= 19'h08000;
    settled_next[1] = cnt_reg >= 19'h20000;
    settled_next[0] = cnt_reg >= 19'h40000;
    if (!osc_running) begin
      settled_next = 8'h00;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      cnt_reg <= '0;
      settled_reg <= 8'h00;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      settled_reg <= settled_next;
    end
  end

endmodule : cs_settle_counter

// File: cs_clock_switch.sv
// Clock-source switch between the sub clock and the main system clock:
// register port, oscillator run controls and the source change sequencer.
// Assumes software on the plain strobe port and oscillators outside the chip.
//
// What this block does
// - Writing 0 to main crystal halt starts the main oscillator.
// - Settle status holds eight flags, 2^8 in bit 7 down to 2^18 in bit 0.
// - Writing 0 to CPU source select chooses the main system clock.
// - Clock select layout: status 7, CPU select 6, main status 5, main select 4.
// - Run control: main halt 7, sub halt 6, middle on 1, fast halt 0.
// - Writing 1 to CPU source select chooses sub clock; clock status reads 1.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module cs_clock_switch
  import cs_pkg::*;
(
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic [DATA_W-1:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [DATA_W-1:0] reg_rdata_reg, // Read data, cycle after reg_rd
  input wire logic main_osc_in, // Main oscillator or external clock output
  output logic main_osc_run_reg, // Enable the main crystal oscillator
  output logic sub_osc_run_reg, // Enable the sub crystal oscillator
  output logic middle_osc_run_reg, // Enable the middle-speed on-chip oscillator
  output logic fast_osc_run_reg, // Enable the fast on-chip oscillator
  output logic core_on_sub_reg, // Core clock taken from the sub clock
  output logic main_settled_reg // Selected settle time has elapsed
);

  // Register state
  logic [SEL_W-1:0] settle_sel_reg, settle_sel_next;
  logic main_halt_reg, main_halt_next;
  logic sub_halt_reg, sub_halt_next;
  logic middle_on_reg, middle_on_next;
  logic fast_halt_reg, fast_halt_next;
  logic cpu_sel_reg, cpu_sel_next;
  logic main_sel_reg, main_sel_next;
  logic aux_sel_reg, aux_sel_next;
  logic main_sts_reg, main_sts_next;
  logic aux_sts_reg, aux_sts_next;
  logic [DATA_W-1:0] reg_rdata_next;

  // Switch sequencer state
  cs_switch_state_t state_reg, state_next;
  logic [3:0] sw_cnt_reg, sw_cnt_next;
  logic clk_status_reg, clk_status_next;

  // Output flops
  logic main_osc_run_next;
  logic sub_osc_run_next;
  logic middle_osc_run_next;
  logic fast_osc_run_next;
  logic main_settled_next;

  // Decoded accesses
  logic wr_sel, wr_run, wr_ckc;
  logic [7:0] settled_flags;
  logic [7:0] settle_sel_view, run_view, ckc_view;

  // Elapsed flags are cleared whenever the main oscillator is halted
  cs_settle_counter u_settle (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .osc_running(main_osc_run_reg),
    .main_osc_in(main_osc_in),
    .settled_reg(settled_flags)
  );

  // Address decode for the write strobe
  assign wr_sel = reg_wr && (reg_addr == OFS_SETTLE_SELECT);
  assign wr_run = reg_wr && (reg_addr == OFS_RUN_CONTROL);
  assign wr_ckc = reg_wr && (reg_addr == OFS_CLOCK_SELECT);

  // Read views; unused bits read as zero
  always_comb begin
    settle_sel_view = 8'h00;
    settle_sel_view[SEL_MSB:0] = settle_sel_reg;
    run_view = 8'h00;
    run_view[BIT_MAIN_HALT] = main_halt_reg;
    run_view[BIT_SUB_HALT] = sub_halt_reg;
    run_view[BIT_MIDDLE_ON] = middle_on_reg;
    run_view[BIT_FAST_HALT] = fast_halt_reg;
    ckc_view = 8'h00;
    ckc_view[BIT_CLK_STATUS] = clk_status_reg;
    ckc_view[BIT_CPU_SRC_SEL] = cpu_sel_reg;
    ckc_view[BIT_MAIN_SRC_STS] = main_sts_reg;
    ckc_view[BIT_MAIN_SRC_SEL] = main_sel_reg;
    ckc_view[BIT_AUX_SRC_STS] = aux_sts_reg;
    ckc_view[BIT_AUX_SRC_SEL] = aux_sel_reg;
  end

  // Register file next values
  always_comb begin
    settle_sel_next = settle_sel_reg;
    main_halt_next = main_halt_reg;
    sub_halt_next = sub_halt_reg;
    middle_on_next = middle_on_reg;
    fast_halt_next = fast_halt_reg;
    cpu_sel_next = cpu_sel_reg;
    main_sel_next = main_sel_reg;
    aux_sel_next = aux_sel_reg;
    if (wr_sel) begin
      settle_sel_next = reg_wdata[SEL_MSB:0];
    end
    if (wr_run) begin
      main_halt_next = reg_wdata[BIT_MAIN_HALT];
      sub_halt_next = reg_wdata[BIT_SUB_HALT];
      middle_on_next = reg_wdata[BIT_MIDDLE_ON];
      fast_halt_next = reg_wdata[BIT_FAST_HALT];
    end
    if (wr_ckc) begin
      cpu_sel_next = reg_wdata[BIT_CPU_SRC_SEL];
      aux_sel_next = reg_wdata[BIT_AUX_SRC_SEL];
      // The main select is frozen while the sub clock drives the core, so the
      // main clock path cannot be retargeted under a running CPU
      if (!clk_status_reg && !cpu_sel_reg) begin
        main_sel_next = reg_wdata[BIT_MAIN_SRC_SEL];
      end
    end
    // Status mirrors of the selects
    main_sts_next = main_sel_reg;
    aux_sts_next = aux_sel_reg;
  end

  // Read data stands for exactly one cycle after the read strobe
  always_comb begin
    reg_rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_SETTLE_SELECT: reg_rdata_next = settle_sel_view;
        OFS_RUN_CONTROL: reg_rdata_next = run_view;
        OFS_SETTLE_STATUS: reg_rdata_next = settled_flags;
        OFS_CLOCK_SELECT: reg_rdata_next = ckc_view;
        default: reg_rdata_next = 8'h00;
      endcase
    end
  end

  // Source change sequencer: the status flag only moves after the change
  // has had SWITCH_CYCLES to complete, so software sees a real handover
  always_comb begin
    state_next = state_reg;
    sw_cnt_next = sw_cnt_reg;
    clk_status_next = clk_status_reg;
    unique case (state_reg)
      CS_ON_MAIN: begin
        clk_status_next = 1'b0;
        if (cpu_sel_reg) begin
          state_next = CS_TO_SUB;
          sw_cnt_next = SWITCH_CYCLES;
        end
      end
      CS_TO_SUB: begin
        if (sw_cnt_reg == 4'h1) begin
          state_next = CS_ON_SUB;
          clk_status_next = 1'b1;
        end else begin
          sw_cnt_next = sw_cnt_reg - 4'h1;
        end
      end
      CS_ON_SUB: begin
        clk_status_next = 1'b1;
        if (!cpu_sel_reg) begin
          state_next = CS_TO_MAIN;
          sw_cnt_next = SWITCH_CYCLES;
        end
      end
      CS_TO_MAIN: begin
        if (sw_cnt_reg == 4'h1) begin
          state_next = CS_ON_MAIN;
          clk_status_next = 1'b0;
        end else begin
          sw_cnt_next = sw_cnt_reg - 4'h1;
        end
      end
    endcase
  end

  // Oscillator run outputs and the settled indication
  always_comb begin
    main_osc_run_next = !main_halt_reg;
    sub_osc_run_next = !sub_halt_reg;
    middle_osc_run_next = middle_on_reg;
    fast_osc_run_next = !fast_halt_reg;
    // Flag for the selected time: select 0 maps to bit 7 (2^8)
    main_settled_next = settled_flags[3'h7 - settle_sel_reg];
  end

  // All registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      settle_sel_reg <= RST_SETTLE_SEL;
      main_halt_reg <= RST_MAIN_HALT;
      sub_halt_reg <= RST_SUB_HALT;
      middle_on_reg <= RST_MIDDLE_ON;
      fast_halt_reg <= RST_FAST_HALT;
      cpu_sel_reg <= RST_CPU_SRC_SEL;
      main_sel_reg <= RST_MAIN_SRC_SEL;
      aux_sel_reg <= RST_AUX_SRC_SEL;
      main_sts_reg <= RST_MAIN_SRC_SEL;
      aux_sts_reg <= RST_AUX_SRC_SEL;
      reg_rdata_reg <= 8'h00;
      state_reg <= CS_ON_MAIN;
      sw_cnt_reg <= 4'h0;
      clk_status_reg <= 1'b0;
      main_osc_run_reg <= 1'b0;
      sub_osc_run_reg <= 1'b0;
      middle_osc_run_reg <= 1'b0;
      fast_osc_run_reg <= 1'b0;
      main_settled_reg <= 1'b0;
    end else begin
      settle_sel_reg <= settle_sel_next;
      main_halt_reg <= main_halt_next;
      sub_halt_reg <= sub_halt_next;
      middle_on_reg <= middle_on_next;
      fast_halt_reg <= fast_halt_next;
      cpu_sel_reg <= cpu_sel_next;
      main_sel_reg <= main_sel_next;
      aux_sel_reg <= aux_sel_next;
      main_sts_reg <= main_sts_next;
      aux_sts_reg <= aux_sts_next;
      reg_rdata_reg <= reg_rdata_next;
      state_reg <= state_next;
      sw_cnt_reg <= sw_cnt_next;
      clk_status_reg <= clk_status_next;
      main_osc_run_reg <= main_osc_run_next;
      sub_osc_run_reg <= sub_osc_run_next;
      middle_osc_run_reg <= middle_osc_run_next;
      fast_osc_run_reg <= fast_osc_run_next;
      main_settled_reg <= main_settled_next;
    end
  end

  // Clock status flag is the core source indication seen outside
  assign core_on_sub_reg = clk_status_reg;

endmodule : cs_clock_switch

// File: cs_main_osc_model.sv
// Behavioural main crystal or external clock source for the clock switch bench.
// Assumes its enable is the block's main oscillator run output.
`timescale 1ns/100ps
module cs_main_osc_model #(
  parameter int HALF_NS = 50 // Half period, 10 MHz output
) (
  input wire logic enable, // Crystal enabled by the block
  input wire logic ext_mode, // External clock present regardless of enable
  output logic osc_out // Oscillator output
);
  // A halted crystal stands still low; an external source runs before the halt is cleared
  initial begin
    osc_out = 1'b0;
    forever begin
      #(HALF_NS);
      if (enable || ext_mode) begin
        osc_out = ~osc_out;
      end else begin
        osc_out = 1'b0;
      end
    end
  end
endmodule : cs_main_osc_model

// File: cs_clock_switch_chk.sv
// Checker for the clock switch: register port relations and source switch timing.
// Assumes it is bound to cs_clock_switch and sees only its ports.
`timescale 1ns/100ps
module cs_clock_switch_chk
  import cs_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic [DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [DATA_W-1:0] reg_rdata_reg, // Read data
  input wire logic main_osc_in, // Main oscillator output
  input wire logic main_osc_run_reg, // Main oscillator enable
  input wire logic sub_osc_run_reg, // Sub oscillator enable
  input wire logic middle_osc_run_reg, // Middle oscillator enable
  input wire logic fast_osc_run_reg, // Fast oscillator enable
  input wire logic core_on_sub_reg, // Core on sub clock
  input wire logic main_settled_reg // Settle time elapsed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic wr_run; // Write to run control
  logic wr_clk; // Write to clock select
  logic [3:0] run_exp; // Enables that the written run control bits imply
  // Decode once so each property reads plainly
  assign wr_run = reg_wr && (reg_addr == OFS_RUN_CONTROL);
  assign wr_clk = reg_wr && (reg_addr == OFS_CLOCK_SELECT);
  assign run_exp = {~reg_wdata[7], ~reg_wdata[6], reg_wdata[1], ~reg_wdata[0]};
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_reg == 8'h00)
    else $error("read data not zero outside the answer cycle");
  AST_RUN_OUTPUTS: assert property (wr_run |-> ##2 ({main_osc_run_reg, sub_osc_run_reg, middle_osc_run_reg,
    fast_osc_run_reg} == $past(run_exp, 2)))
    else $error("oscillator enables do not follow run control");
  AST_TO_SUB: assert property (wr_clk && reg_wdata[6] && !core_on_sub_reg |-> ##[5:7] core_on_sub_reg)
    else $error("core did not move to the sub clock");
  AST_TO_MAIN: assert property (wr_clk && !reg_wdata[6] && core_on_sub_reg |-> ##[5:7] !core_on_sub_reg)
    else $error("core did not move to the main clock");
  AST_HALT_CLEARS: assert property ($fell(main_osc_run_reg) |-> ##[1:4] !main_settled_reg)
    else $error("settled flag survived a main halt");
  AST_SETTLE_RUNNING: assert property ($rose(main_settled_reg) |-> main_osc_run_reg && $past(main_osc_run_reg, 8))
    else $error("settled flag rose without a running oscillator");
  AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr > OFS_CLOCK_SELECT |=> reg_rdata_reg == 8'h00)
    else $error("unmapped read not zero");
  AST_SELECT_UPPER: assert property (reg_rd && reg_addr == OFS_SETTLE_SELECT |=> reg_rdata_reg[7:3] == 5'h00)
    else $error("settle select upper bits not zero");
  AST_RUN_RSVD: assert property (reg_rd && reg_addr == OFS_RUN_CONTROL |=> reg_rdata_reg[5:2] == 4'h0)
    else $error("run control reserved bits not zero");
  AST_CLK_RSVD: assert property (reg_rd && reg_addr == OFS_CLOCK_SELECT |=> reg_rdata_reg[3:2] == 2'h0)
    else $error("clock select reserved bits not zero");
endmodule : cs_clock_switch_chk

bind cs_clock_switch cs_clock_switch_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
  .main_osc_in(main_osc_in), .main_osc_run_reg(main_osc_run_reg), .sub_osc_run_reg(sub_osc_run_reg),
  .middle_osc_run_reg(middle_osc_run_reg), .fast_osc_run_reg(fast_osc_run_reg),
  .core_on_sub_reg(core_on_sub_reg), .main_settled_reg(main_settled_reg));

// File: tb_cs_clock_switch.sv
// Self-checking bench for the clock switch: register tasks and a sub-to-main switch.
// Assumes the 10 MHz oscillator model on main_osc_in and a 50 MHz ref_clk.
`timescale 1ns/100ps
module tb_cs_clock_switch;
  import cs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_mode = 1'b0;
  logic [7:0] reg_rdata_reg;
  logic main_osc_in;
  logic main_osc_run_reg;
  logic sub_osc_run_reg;
  logic middle_osc_run_reg;
  logic fast_osc_run_reg;
  logic core_on_sub_reg;
  logic main_settled_reg;
  logic [7:0] rd_val;
  int failures = 0;
  int num_checks = 0;

  // 50 MHz reference clock
  always #10 ref_clk = ~ref_clk;

  cs_clock_switch i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg), .main_osc_in(main_osc_in),
    .main_osc_run_reg(main_osc_run_reg), .sub_osc_run_reg(sub_osc_run_reg),
    .middle_osc_run_reg(middle_osc_run_reg), .fast_osc_run_reg(fast_osc_run_reg),
    .core_on_sub_reg(core_on_sub_reg), .main_settled_reg(main_settled_reg));
  cs_main_osc_model i_osc (.enable(main_osc_run_reg), .ext_mode(ext_mode), .osc_out(main_osc_in));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : check

  // One-cycle strobes; the next call waits an edge, so no signal is driven twice at once
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Data stand only in the cycle after the strobe; taken at the edge closing it
  task automatic read_check(input string name, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    rd_val = reg_rdata_reg;
    if (name != "") check(name, exp, rd_val);
  endtask : read_check

  task automatic outs_check(input logic [3:0] exp);
    repeat (3) @(posedge ref_clk);
    check("osc_run", {4'h0, exp}, {4'h0, main_osc_run_reg, sub_osc_run_reg, middle_osc_run_reg, fast_osc_run_reg});
  endtask : outs_check

  task automatic print_verdict;
    $display("Checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // The sequence needs about 134 us; well over twice that marks a hang
  initial begin
    #400000;
    failures++;
    print_verdict();
  end

  initial begin : main_seq
    int n;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    read_check("settle_select", OFS_SETTLE_SELECT, 8'h07);
    read_check("run_control", OFS_RUN_CONTROL, 8'hc0);
    read_check("settle_status", OFS_SETTLE_STATUS, 8'h00);
    read_check("clock_select", OFS_CLOCK_SELECT, 8'h00);
    read_check("unmapped", 8'h04, 8'h00);
    reg_write(OFS_SETTLE_STATUS, 8'hff);
    read_check("status_ro", OFS_SETTLE_STATUS, 8'h00);
    reg_write(OFS_SETTLE_SELECT, 8'hff);
    read_check("select_upper", OFS_SETTLE_SELECT, 8'h07);
    reg_write(OFS_SETTLE_SELECT, 8'h02);
    read_check("select_10mhz", OFS_SETTLE_SELECT, 8'h02);
    reg_write(OFS_RUN_CONTROL, 8'hff);
    read_check("run_rsvd", OFS_RUN_CONTROL, 8'hc3);
    outs_check(4'b0010);
    // Park the core on the sub clock while the crystal is still halted; main select set on the way
    reg_write(OFS_RUN_CONTROL, 8'h80);
    outs_check(4'b0101);
    reg_write(OFS_CLOCK_SELECT, 8'h50);
    repeat (10) @(posedge ref_clk);
    check("on_sub", 8'h01, {7'h00, core_on_sub_reg});
    read_check("clk_on_sub", OFS_CLOCK_SELECT, 8'hf0);
    reg_write(OFS_CLOCK_SELECT, 8'h40);
    read_check("main_sel_blocked", OFS_CLOCK_SELECT, 8'hf0);
    // Start the crystal and poll the flags, which must fill from the top down
    reg_write(OFS_RUN_CONTROL, 8'h00);
    outs_check(4'b1101);
    n = 0;
    rd_val = 8'h00;
    while (rd_val[5] !== 1'b1 && n < 4000) begin
      read_check("", OFS_SETTLE_STATUS, 8'h00);
      check("flag_order", 8'h00, (rd_val << 1) & ~rd_val);
      n++;
    end
    check("status_102us", 8'he0, rd_val);
    repeat (3) @(posedge ref_clk);
    check("settled", 8'h01, {7'h00, main_settled_reg});
    // CPU select cleared while main select still reads 1
    reg_write(OFS_CLOCK_SELECT, 8'h10);
    repeat (10) @(posedge ref_clk);
    check("on_main", 8'h00, {7'h00, core_on_sub_reg});
    read_check("main_status", OFS_CLOCK_SELECT, 8'h30);
    reg_write(OFS_CLOCK_SELECT, 8'h11);
    read_check("main_source", OFS_CLOCK_SELECT, 8'h33);
    // Sub crystal stops only once the core is on main
    reg_write(OFS_RUN_CONTROL, 8'h40);
    outs_check(4'b1001);
    reg_write(OFS_RUN_CONTROL, 8'hc0);
    outs_check(4'b0001);
    read_check("status_cleared", OFS_SETTLE_STATUS, 8'h00);
    check("unsettled", 8'h00, {7'h00, main_settled_reg});
    // External main clock: present before the halt clears, then a direct switch with no settle wait
    reg_write(OFS_RUN_CONTROL, 8'h80);
    reg_write(OFS_CLOCK_SELECT, 8'h50);
    repeat (10) @(posedge ref_clk);
    check("ext_on_sub", 8'h01, {7'h00, core_on_sub_reg});
    ext_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_write(OFS_RUN_CONTROL, 8'h00);
    reg_write(OFS_CLOCK_SELECT, 8'h10);
    repeat (10) @(posedge ref_clk);
    check("ext_on_main", 8'h00, {7'h00, core_on_sub_reg});
    // About 280 external edges by now: only the first flag may stand
    repeat (1400) @(posedge ref_clk);
    read_check("ext_counted", OFS_SETTLE_STATUS, 8'h80);
    print_verdict();
  end
endmodule : tb_cs_clock_switch
